// ===== verilog/pot_pkg.sv
/*
  Package for the permissive over-reaching trip scheme logic.
  Holds register offsets, field positions, reset values and timing defaults.
  Assumes a 40 MHz APB clock; times are given in microseconds.
*/
package pot_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TIMER_W         = 32;
  localparam logic [7:0]  CTRL_OFF        = 8'h00;
  localparam logic [7:0]  RXQ_OFF         = 8'h04;
  localparam logic [7:0]  TPASS_OFF       = 8'h08;
  localparam logic [7:0]  TBLK_OFF        = 8'h0c;
  localparam logic [7:0]  ECHO_DUR_OFF    = 8'h10;
  localparam logic [7:0]  ECHO_LOCK_OFF   = 8'h14;
  localparam logic [7:0]  OPEN_END_OFF    = 8'h18;
  localparam logic [7:0]  HOLD_OFF        = 8'h1c;
  localparam logic [7:0]  STATUS_OFF      = 8'h20;
  localparam int unsigned CTRL_ECHO_BIT   = 0;
  localparam int unsigned CTRL_GND_BIT    = 1;
  localparam int unsigned ST_RXQ_BIT      = 0;
  localparam int unsigned ST_OPEN_BIT     = 1;
  localparam int unsigned ST_PASS_BIT     = 2;
  localparam int unsigned ST_BLOCK_BIT    = 3;
  localparam int unsigned ST_ECHO_BIT     = 4;
  localparam int unsigned ST_LOCK_BIT     = 5;
  localparam int unsigned ST_TX_BIT       = 6;
  localparam int unsigned ST_TRIP_BIT     = 7;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam int unsigned RXQ_US          = 4_000;
  localparam int unsigned TPASS_US        = 30_000;
  localparam int unsigned TBLK_US         = 90_000;
  localparam int unsigned ECHO_DUR_US     = 100_000;
  localparam int unsigned ECHO_LOCK_US    = 250_000;
  localparam int unsigned OPEN_END_US     = 50_000;
  localparam int unsigned HOLD_US         = 10_000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam logic [TIMER_W-1:0] RXQ_RST       = TIMER_W'(RXQ_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] TPASS_RST     =
    TIMER_W'(TPASS_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] TBLK_RST      =
    TIMER_W'(TBLK_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] ECHO_DUR_RST  =
    TIMER_W'(ECHO_DUR_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] ECHO_LOCK_RST =
    TIMER_W'(ECHO_LOCK_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] OPEN_END_RST  =
    TIMER_W'(OPEN_END_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] HOLD_RST      =
    TIMER_W'(HOLD_US * CYC_PER_US);
endpackage

// ===== verilog/pot_trip.sv
/*
  Permissive over-reaching transfer-trip scheme logic with APB settings.
  Register map, one 32-bit word each at byte addresses:
    0x00 control: bit 0 enables the echo, bit 1 the ground path.
    0x04 receive qualify delay, in clock cycles.
    0x08 transient pass window, in clock cycles.
    0x0c transient block hold, in clock cycles.
    0x10 echo duration, in clock cycles; zero turns the echo off.
    0x14 echo lockout, in clock cycles.
    0x18 open line end qualify delay, in clock cycles.
    0x1c trip hold time, in clock cycles.
    0x20 status, read only: qualified receive, valid open end, pass
         window, block hold, echo, lockout, transmit and trip, from
         bit 0 upwards.
  Assumes all scheme inputs are synchronous to pclk and the APB master
  follows the standard setup/access protocol.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - One echo, then lockout for echo lockout time.
// - Echo pulse length equals configured echo duration.
// - Receive acted on after qualify delay held.
// - Ground path passes only in window, then blocked.
// - Pass window timed from first transmit assertion.
// - Transient blocking gates only ground path.
// - Open end valid after qualify delay held.
// - Echo only with open end and enabled.
// - Trip output held at least hold time.
// - Ground forward input keys transmit, starts scheme.
// - Receive on input; transmit drives channel output.
// - Zone forward detection keys transmit output.
// - Echo is one-shot on qualified receive.
module pot_trip
  import pot_pkg::*;
#(
  parameter int unsigned W = TIMER_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        permissive_receive_in,
  input  wire logic        zone_forward_in,
  input  wire logic        ground_directional_forward,
  input  wire logic        open_end_detect_in,
  output logic             permissive_transmit_out,
  output logic             scheme_trip_out
);

  logic [1:0]   ctrl;
  logic [W-1:0] receive_qualify_delay;
  logic [W-1:0] transient_pass_window;
  logic [W-1:0] transient_block_hold;
  logic [W-1:0] echo_duration;
  logic [W-1:0] echo_lockout;
  logic [W-1:0] open_end_delay;
  logic [W-1:0] trip_hold_time;

  logic [W-1:0] rx_cnt;
  logic [W-1:0] oe_cnt;
  logic [W-1:0] pass_cnt;
  logic [W-1:0] blk_cnt;
  logic [W-1:0] echo_cnt;
  logic [W-1:0] lock_cnt;
  logic [W-1:0] hold_cnt;
  logic         rx_qual;
  logic         open_end_valid;
  logic         pass_active;
  logic         pass_done;
  logic         block_active;
  logic         echo_active;
  logic         lock_active;
  logic         echo_on_d;
  logic [7:0]   status_bits;

  wire logic echo_feature_on = ctrl[CTRL_ECHO_BIT];
  wire logic ground_enable   = ctrl[CTRL_GND_BIT];
  wire logic gnd_fwd         = ground_enable & ground_directional_forward;
  wire logic keying          = zone_forward_in | gnd_fwd;
  wire logic gnd_path        = gnd_fwd & pass_active &
                               ~block_active;
  wire logic trip_cond       = rx_qual & (zone_forward_in | gnd_path);
  wire logic echo_fire       = rx_qual & open_end_valid & echo_feature_on &
                               ~echo_active & ~lock_active & ~echo_on_d;
  wire logic wr_en = psel & penable & pwrite;

  // Settings registers written over APB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                  <= CTRL_RESET;
      receive_qualify_delay <= RXQ_RST;
      transient_pass_window <= TPASS_RST;
      transient_block_hold  <= TBLK_RST;
      echo_duration         <= ECHO_DUR_RST;
      echo_lockout          <= ECHO_LOCK_RST;
      open_end_delay        <= OPEN_END_RST;
      trip_hold_time        <= HOLD_RST;
    end else if (wr_en) begin
      if (paddr == CTRL_OFF) begin
        ctrl <= pwdata[1:0];
      end else if (paddr == RXQ_OFF) begin
        receive_qualify_delay <= pwdata[W-1:0];
      end else if (paddr == TPASS_OFF) begin
        transient_pass_window <= pwdata[W-1:0];
      end else if (paddr == TBLK_OFF) begin
        transient_block_hold <= pwdata[W-1:0];
      end else if (paddr == ECHO_DUR_OFF) begin
        echo_duration <= pwdata[W-1:0];
      end else if (paddr == ECHO_LOCK_OFF) begin
        echo_lockout <= pwdata[W-1:0];
      end else if (paddr == OPEN_END_OFF) begin
        open_end_delay <= pwdata[W-1:0];
      end else if (paddr == HOLD_OFF) begin
        trip_hold_time <= pwdata[W-1:0];
      end
    end
  end

  // Status word, with every flag at its own bit position.
  always_comb begin
    status_bits                = 8'h00;
    status_bits[ST_RXQ_BIT]    = rx_qual;
    status_bits[ST_OPEN_BIT]   = open_end_valid;
    status_bits[ST_PASS_BIT]   = pass_active;
    status_bits[ST_BLOCK_BIT]  = block_active;
    status_bits[ST_ECHO_BIT]   = echo_active;
    status_bits[ST_LOCK_BIT]   = lock_active;
    status_bits[ST_TX_BIT]     = permissive_transmit_out;
    status_bits[ST_TRIP_BIT]   = scheme_trip_out;
  end

  // Read data, ready and error; every access completes in its first
  // access cycle, and unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel & ~penable) begin
        if (paddr == CTRL_OFF) begin
          prdata <= {30'h0, ctrl};
        end else if (paddr == RXQ_OFF) begin
          prdata <= 32'(receive_qualify_delay);
        end else if (paddr == TPASS_OFF) begin
          prdata <= 32'(transient_pass_window);
        end else if (paddr == TBLK_OFF) begin
          prdata <= 32'(transient_block_hold);
        end else if (paddr == ECHO_DUR_OFF) begin
          prdata <= 32'(echo_duration);
        end else if (paddr == ECHO_LOCK_OFF) begin
          prdata <= 32'(echo_lockout);
        end else if (paddr == OPEN_END_OFF) begin
          prdata <= 32'(open_end_delay);
        end else if (paddr == HOLD_OFF) begin
          prdata <= 32'(trip_hold_time);
        end else if (paddr == STATUS_OFF) begin
          prdata <= {24'h0, status_bits};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Receive qualification: input must stay high for the delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt  <= '0;
      rx_qual <= 1'b0;
    end else if (!permissive_receive_in) begin
      rx_cnt  <= '0;
      rx_qual <= 1'b0;
    end else if (rx_cnt >= receive_qualify_delay) begin
      rx_qual <= 1'b1;
    end else begin
      rx_cnt <= rx_cnt + 1'b1;
    end
  end

  // Open line end validation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt         <= '0;
      open_end_valid <= 1'b0;
    end else if (!open_end_detect_in) begin
      oe_cnt         <= '0;
      open_end_valid <= 1'b0;
    end else if (oe_cnt >= open_end_delay) begin
      open_end_valid <= 1'b1;
    end else begin
      oe_cnt <= oe_cnt + 1'b1;
    end
  end

  // Transient pass window from first transmit, then block hold.
  // The window rearms only once transmit has dropped and the hold is
  // over, so one long keying opens one window only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_cnt     <= '0;
      pass_active  <= 1'b0;
      pass_done    <= 1'b0;
      blk_cnt      <= '0;
      block_active <= 1'b0;
    end else begin
      if (!permissive_transmit_out && !pass_active && !block_active) begin
        pass_done <= 1'b0;
      end
      if (permissive_transmit_out && !pass_active && !pass_done) begin
        pass_active <= 1'b1;
        pass_done   <= 1'b1;
        pass_cnt    <= '0;
      end else if (pass_active) begin
        if (pass_cnt + 1'b1 >= transient_pass_window) begin
          pass_active  <= 1'b0;
          block_active <= 1'b1;
          blk_cnt      <= '0;
        end else begin
          pass_cnt <= pass_cnt + 1'b1;
        end
      end else if (block_active) begin
        if (blk_cnt + 1'b1 >= transient_block_hold) begin
          block_active <= 1'b0;
        end else begin
          blk_cnt <= blk_cnt + 1'b1;
        end
      end
    end
  end

  // Echo one-shot with lockout. The lockout stops an echoed signal
  // from bouncing between the two line ends for ever.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_cnt    <= '0;
      echo_active <= 1'b0;
      lock_cnt    <= '0;
      lock_active <= 1'b0;
      echo_on_d   <= 1'b0;
    end else begin
      echo_on_d <= echo_active;
      if (echo_fire && echo_duration != '0) begin
        echo_active <= 1'b1;
        echo_cnt    <= '0;
      end else if (echo_active) begin
        if (echo_cnt + 1'b1 >= echo_duration) begin
          echo_active <= 1'b0;
          lock_active <= 1'b1;
          lock_cnt    <= '0;
        end else begin
          echo_cnt <= echo_cnt + 1'b1;
        end
      end else if (lock_active) begin
        if (lock_cnt + 1'b1 >= echo_lockout) begin
          lock_active <= 1'b0;
        end else begin
          lock_cnt <= lock_cnt + 1'b1;
        end
      end
    end
  end

  // Transmit output and sealed-in trip output.
  // The hold counter restarts while the trip condition stands, so the
  // output outlasts a chattering receive by at least the hold time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permissive_transmit_out <= 1'b0;
      scheme_trip_out         <= 1'b0;
      hold_cnt                <= '0;
    end else begin
      permissive_transmit_out <= keying | echo_active;
      if (trip_cond) begin
        scheme_trip_out <= 1'b1;
        hold_cnt        <= '0;
      end else if (scheme_trip_out) begin
        if (hold_cnt + 1'b1 >= trip_hold_time) begin
          scheme_trip_out <= 1'b0;
        end else begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== dv/pot_monitor.sv
/* Checker for the trip scheme block, watching its ports only.
   Bound to every pot_trip instance by the bind below. */
`timescale 1ns/1ps
`default_nettype none
module pot_monitor #(
  parameter int unsigned W = 32
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        permissive_receive_in,
  input wire logic        zone_forward_in,
  input wire logic        ground_directional_forward,
  input wire logic        open_end_detect_in,
  input wire logic        permissive_transmit_out,
  input wire logic        scheme_trip_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  apb_ready_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("no ready in first access cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  trip_hold_a: assert property (
    $rose(scheme_trip_out) |-> scheme_trip_out [*8])
    else $error("trip output too short");
  trip_rx_a: assert property (
    $rose(scheme_trip_out) |-> $past(permissive_receive_in, 2)
      && $past(permissive_receive_in, 3))
    else $error("trip without held receive");
  trip_fwd_a: assert property (
    $rose(scheme_trip_out) |->
      $past(zone_forward_in) || $past(ground_directional_forward))
    else $error("trip without forward detection");
  zone_key_a: assert property (
    zone_forward_in |=> permissive_transmit_out)
    else $error("zone forward did not key transmit");
  echo_open_a: assert property (
    $rose(permissive_transmit_out) && !$past(zone_forward_in)
      && !$past(ground_directional_forward) |-> $past(open_end_detect_in))
    else $error("echo without open line end");
endmodule
bind pot_trip pot_monitor #(.W(W)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .permissive_receive_in(permissive_receive_in),
  .zone_forward_in(zone_forward_in),
  .ground_directional_forward(ground_directional_forward),
  .open_end_detect_in(open_end_detect_in),
  .permissive_transmit_out(permissive_transmit_out),
  .scheme_trip_out(scheme_trip_out));
`default_nettype wire

// ===== dv/pot_chan.sv
/* Signalling channel model: delays the remote keying onto the receive
   line and counts transmit pulses arriving at the remote end. */
`timescale 1ns/1ps
`default_nettype none
module pot_chan #(
  parameter int DLY = 2
) (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  remote_key,
  input wire logic  tx,
  output logic      rx,
  output logic [7:0] tx_rises
);
  logic [DLY-1:0] pipe;
  logic           tx_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe <= '0;
      tx_d <= 1'b0;
      tx_rises <= 8'h00;
    end else begin
      pipe <= {pipe[DLY-2:0], remote_key};
      tx_d <= tx;
      if (tx && !tx_d) tx_rises <= tx_rises + 8'h01;
    end
  end
  assign rx = pipe[DLY-1];
endmodule
`default_nettype wire

// ===== dv/pot_trip_tb.sv
/* Self-checking bench for the trip scheme block with channel model.
   Needs pot_pkg, pot_trip, pot_chan and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module pot_trip_tb;
  import pot_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd95;
  logic pready, pslverr, err, rx, tx, trip;
  logic zone = 0, gnd = 0, open = 0, key = 0;
  logic [7:0] rises, r0;
  logic [7:0] offs [7] = '{RXQ_OFF, TPASS_OFF, TBLK_OFF, ECHO_DUR_OFF,
                          ECHO_LOCK_OFF, OPEN_END_OFF, HOLD_OFF};
  int vals [7] = '{5, 20, 10, 6, 60, 5, 12};
  int exp_echo [$] = '{6, 0, 0};
  int failures = 0, checks = 0, c;
  always #12.5 pclk = ~pclk;
  pot_trip DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .permissive_receive_in(rx), .zone_forward_in(zone),
    .ground_directional_forward(gnd), .open_end_detect_in(open),
    .permissive_transmit_out(tx), .scheme_trip_out(trip));
  pot_chan CH (.pclk(pclk), .presetn(presetn), .remote_key(key), .tx(tx),
    .rx(rx), .tx_rises(rises));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic cnt_tx(int n);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (tx === 1'b1) c++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(4000);
    failures++;
    finish_test();
  end
  initial begin
    cyc(8);
    presetn <= 1'b1;
    apb(0, CTRL_OFF, 0);
    chk("ctrl", rd, 32'(CTRL_RESET));
    apb(0, HOLD_OFF, 0);
    chk("hold", rd, HOLD_RST);
    apb(0, 8'h40, 0);
    chk("unmapped err", 32'(err), 1);
    chk("unmapped data", rd, 0);
    foreach (offs[i]) apb(1, offs[i], vals[i]);
    apb(0, ECHO_LOCK_OFF, 0);
    chk("lock", rd, 60);
    $display("registers done");
    zone <= 1'b1;
    cyc(4);
    chk("zone tx", tx, 1);
    key <= 1'b1;
    cyc(int'(xs() % 3) + 1);
    key <= 1'b0;
    cyc(12);
    chk("short rx trip", trip, 0);
    key <= 1'b1;
    cyc(5);
    chk("early trip", trip, 0);
    cyc(10);
    chk("trip", trip, 1);
    zone <= 1'b0;
    key <= 1'b0;
    cyc(4);
    chk("sealed trip", trip, 1);
    cyc(20);
    chk("trip end", trip, 0);
    $display("zone path done");
    apb(1, CTRL_OFF, 1);
    open <= 1'b1;
    apb(0, STATUS_OFF, 0);
    chk("open early", rd[ST_OPEN_BIT], 0);
    cyc(4);
    apb(0, STATUS_OFF, 0);
    chk("open valid", rd[ST_OPEN_BIT], 1);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) cyc(60);
      if (k == 2) open <= 1'b0;
      cyc(10);
      r0 = rises;
      key <= 1'b1;
      cyc(10);
      key <= 1'b0;
      cnt_tx(30);
      chk("echo length", c, exp_echo.pop_front());
      chk("echo count", 32'(rises - r0), k == 0);
    end
    $display("echo done");
    apb(1, CTRL_OFF, 2);
    key <= 1'b1;
    gnd <= 1'b1;
    cyc(3);
    chk("ground tx", tx, 1);
    cyc(9);
    chk("ground trip", trip, 1);
    cyc(14);
    apb(0, STATUS_OFF, 0);
    chk("block hold", rd[ST_BLOCK_BIT], 1);
    chk("window over", rd[ST_PASS_BIT], 0);
    cyc(13);
    chk("blocked trip", trip, 0);
    zone <= 1'b1;
    cyc(4);
    chk("zone unblocked", trip, 1);
    zone <= 1'b0;
    gnd <= 1'b0;
    key <= 1'b0;
    cyc(20);
    $display("ground path done");
    finish_test();
  end
endmodule
`default_nettype wire
